// file: hw/irq_ctrl_consts.svh
// Constants of the two level interrupt controller.
// Assumes inclusion by the controller and by the test bench only.
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH
// Register indices; byte address is four times the index
`define IC_PRIO_IDX 14'h0EB5
`define IC_ENAB_IDX 14'h0EBD
`define IC_FLAG_IDX 14'h0EC5
`define IC_CTRL_IDX 14'h0FF2
`define IC_BANK_REGS 14'h0008
// Control register fields
`define IC_GH_BIT 7
`define IC_PL_BIT 6
`define IC_PM_BIT 5
`define IC_CTRL_MASK 8'hE7
`define IC_CTRL_RST 8'h07
// Vectors
`define IC_VEC_HIGH 21'h000008
`define IC_VEC_LOW 21'h000018
// Instruction strobes from visible request to dispatch
`define IC_LAT_STROBES 2'h3
// Bus responses
`define IC_RESP_OKAY 2'h0
`define IC_RESP_SLVERR 2'h2
`endif

// file: hw/irq_ctrl_pkg.sv
// Types of the two level interrupt controller.
// Assumes a 16-bit AXI4-Lite byte address and 32-bit data.
package irq_ctrl_pkg;
  localparam int NREGS = 8;
  localparam int NSRC  = 8 * NREGS;

  typedef struct packed {
    logic        gh;
    logic        pl;
    logic        pm;
    logic [1:0]  rsvd;
    logic [2:0]  edge_sel;
  } ctrl_t;

  typedef enum logic [3:0] {
    SVC_NONE = 4'h1,
    SVC_LOW  = 4'h2,
    SVC_HIGH = 4'h4,
    SVC_NEST = 4'h8
  } svc_t;

  typedef struct packed {
    logic [15:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [15:0] araddr;
    logic        arvalid;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axi_rsp_t;

  typedef struct packed {
    logic       hit;
    logic [1:0] kind;
    logic [2:0] sel;
  } dec_t;

  typedef struct packed {
    logic [NSRC-1:0] flags;
    logic [NSRC-1:0] enab;
    logic [NSRC-1:0] prio;
    ctrl_t           ctrl;
    svc_t            svc;
    logic [1:0]      lat;
    logic [2:0]      pin_q;
    logic            aw_full;
    logic [13:0]     aw_idx;
    logic            w_full;
    logic [7:0]      w_byte;
    logic            w_lane;
    axi_rsp_t        rsp;
    logic            pc_load;
    logic            push;
    logic [20:0]     vector;
  } state_t;
endpackage : irq_ctrl_pkg

// file: hw/irq_ctrl.sv
// Two level priority interrupt controller with AXI4-Lite registers.
// Assumes core strobes one pulse per instruction cycle and a
// one-cycle pulse when it executes the return from interrupt.
// Function
// [R1] High vector 0008h, low vector 0018h
// [R2] High request pre-empts running low service
// [R3] Per source flag, enable, priority bits
// [R4] Compatibility mode ignores priority bits
// [R5] Compat: peripherals need both global enables
// [R6] Compat: global enable gates everything
// [R7] Compat: every interrupt uses vector 0008h
// [R8] Priority: global high enables high sources
// [R9] Priority: global high clear blocks all
// [R10] Priority: low needs both global enables
// [R11] Entry clears enable of serviced level
// [R12] Low held off during high service
// [R13] Entry pushes return, loads vector
// [R14] Software clears flags before re-enabling
// [R15] Return restores serviced level enable
// [R16] Pin event latency three to four cycles
// [R17] Flags set regardless of enables
// [R18] Eight flag, enable, priority registers
// [R19] Control register read and write
// [R20] No memory move on enabled controls
// [R21] External pins edge triggered, selectable
// [R22] High wins over simultaneous low
`include "irq_ctrl_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl (
  // Clock, reset, enable
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  ce_i,
  // Register bus
  input  wire irq_ctrl_pkg::axi_req_t axi_req_i,
  output var  irq_ctrl_pkg::axi_rsp_t axi_rsp_o,
  // Sources
  input  wire logic [2:0]            ext_pin_i,
  input  wire logic [63:0]           event_i,
  // Core side
  input  wire logic                  instr_strobe_i,
  input  wire logic                  ret_instr_i,
  output logic                       pc_load_o,
  output logic                       push_stack_o,
  output logic [20:0]                vector_o
);
  import irq_ctrl_pkg::*;

  state_t st;
  state_t next_st;

  function automatic state_t reset_state();
    state_t r;
    r             = '0;
    r.ctrl        = ctrl_t'(`IC_CTRL_RST);
    r.svc         = SVC_NONE;
    r.rsp.awready = 1'b1;
    r.rsp.wready  = 1'b1;
    r.rsp.arready = 1'b1;
    return r;
  endfunction : reset_state

  function automatic dec_t decode(input logic [13:0] idx);
    dec_t        d;
    logic [13:0] dp;
    logic [13:0] de;
    logic [13:0] df;
    d  = '0;
    dp = idx - `IC_PRIO_IDX;
    de = idx - `IC_ENAB_IDX;
    df = idx - `IC_FLAG_IDX;
    // [R18] eight registers per bank
    if (dp < `IC_BANK_REGS)
    begin
      d = '{1'b1, 2'd0, dp[2:0]};
    end
    else if (de < `IC_BANK_REGS)
    begin
      d = '{1'b1, 2'd1, de[2:0]};
    end
    else if (df < `IC_BANK_REGS)
    begin
      d = '{1'b1, 2'd2, df[2:0]};
    end
    else if (idx == `IC_CTRL_IDX)
    begin
      d = '{1'b1, 2'd3, 3'd0};
    end
    return d;
  endfunction : decode

  function automatic logic [7:0] rd_byte(input state_t s,
                                         input dec_t d);
    logic [7:0] v;
    v = 8'h00;
    case (d.kind)
      2'd0: v = s.prio[{d.sel, 3'b000} +: 8];
      2'd1: v = s.enab[{d.sel, 3'b000} +: 8];
      2'd2: v = s.flags[{d.sel, 3'b000} +: 8];
      default: v = s.ctrl & `IC_CTRL_MASK;
    endcase
    return v;
  endfunction : rd_byte

  // Combinational helpers
  logic [2:0]      rise;
  logic [2:0]      fall;
  logic [2:0]      pin_ev;
  logic [NSRC-1:0] act;
  logic            hi_req;
  logic            lo_req;
  logic            in_high;
  logic            fire;
  dec_t            wdec;
  dec_t            rdec;

  always_comb
  begin
    next_st         = st;
    next_st.pc_load = 1'b0;
    next_st.push    = 1'b0;
    wdec            = decode(st.aw_idx);
    rdec            = decode(axi_req_i.araddr[15:2]);

    // [R21] edge select per pin
    rise           = ext_pin_i & ~st.pin_q;
    fall           = ~ext_pin_i & st.pin_q;
    pin_ev         = (st.ctrl.edge_sel & rise) |
                     (~st.ctrl.edge_sel & fall);
    next_st.pin_q  = ext_pin_i;

    // Write address and data taken independently
    if (axi_req_i.awvalid && st.rsp.awready)
    begin
      next_st.aw_full = 1'b1;
      next_st.aw_idx  = axi_req_i.awaddr[15:2];
    end
    if (axi_req_i.wvalid && st.rsp.wready)
    begin
      next_st.w_full = 1'b1;
      next_st.w_byte = axi_req_i.wdata[7:0];
      next_st.w_lane = axi_req_i.wstrb[0];
    end
    if (st.rsp.bvalid && axi_req_i.bready)
    begin
      next_st.rsp.bvalid = 1'b0;
    end
    if (st.aw_full && st.w_full && !st.rsp.bvalid)
    begin
      next_st.aw_full    = 1'b0;
      next_st.w_full     = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp  = wdec.hit ? `IC_RESP_OKAY
                                    : `IC_RESP_SLVERR;
      // Only byte lane 0 holds register bits
      if (wdec.hit && st.w_lane)
      begin
        case (wdec.kind)
          // [R3] priority select bits
          2'd0: next_st.prio[{wdec.sel, 3'b000} +: 8] = st.w_byte;
          // [R3] enable bits
          2'd1: next_st.enab[{wdec.sel, 3'b000} +: 8] = st.w_byte;
          // [R14] software clears flag bits here
          2'd2: next_st.flags[{wdec.sel, 3'b000} +: 8] = st.w_byte;
          // [R19] control register write
          default: next_st.ctrl = ctrl_t'(st.w_byte & `IC_CTRL_MASK);
        endcase
      end
    end
    next_st.rsp.awready = !next_st.aw_full;
    next_st.rsp.wready  = !next_st.w_full;

    // Read channel, one outstanding read
    if (st.rsp.rvalid && axi_req_i.rready)
    begin
      next_st.rsp.rvalid  = 1'b0;
      next_st.rsp.arready = 1'b1;
    end
    if (axi_req_i.arvalid && st.rsp.arready)
    begin
      next_st.rsp.arready = 1'b0;
      next_st.rsp.rvalid  = 1'b1;
      next_st.rsp.rdata   = {24'h000000, rdec.hit ? rd_byte(st, rdec)
                                                  : 8'h00};
      next_st.rsp.rresp   = rdec.hit ? `IC_RESP_OKAY
                                     : `IC_RESP_SLVERR;
    end

    // [R17] set wins over software clear
    next_st.flags = next_st.flags | event_i | {61'h0, pin_ev};

    // Request qualification from registered state
    act     = st.flags & st.enab;
    in_high = (st.svc == SVC_HIGH) || (st.svc == SVC_NEST);
    if (!st.ctrl.pm)
    begin
      // [R4] [R5] [R6] compatibility gating
      hi_req = st.ctrl.gh &&
               ((|act[7:0]) || (st.ctrl.pl && (|act[NSRC-1:8])));
      lo_req = 1'b0;
    end
    else
    begin
      // [R8] [R9] high level gating
      hi_req = st.ctrl.gh && (|(act & st.prio));
      // [R10] [R12] low needs both, not during high
      lo_req = st.ctrl.gh && st.ctrl.pl && !in_high &&
               (|(act & ~st.prio));
    end

    // Return from interrupt, before any new entry
    if (ret_instr_i)
    begin
      // [R15] restore serviced level enable
      case (st.svc)
        SVC_HIGH:
        begin
          next_st.ctrl.gh = 1'b1;
          next_st.svc     = SVC_NONE;
        end
        SVC_NEST:
        begin
          next_st.ctrl.gh = 1'b1;
          next_st.svc     = SVC_LOW;
        end
        SVC_LOW:
        begin
          next_st.ctrl.pl = 1'b1;
          next_st.svc     = SVC_NONE;
        end
        default: next_st.ctrl.gh = 1'b1;
      endcase
    end

    // [R16] count whole instruction cycles only
    fire = 1'b0;
    if (!(hi_req || lo_req))
    begin
      next_st.lat = 2'h0;
    end
    else if (instr_strobe_i)
    begin
      if (st.lat == `IC_LAT_STROBES - 2'h1)
      begin
        fire        = 1'b1;
        next_st.lat = 2'h0;
      end
      else
      begin
        next_st.lat = st.lat + 2'h1;
      end
    end

    if (fire)
    begin
      // [R13] push return address and load vector
      next_st.pc_load = 1'b1;
      next_st.push    = 1'b1;
      // [R22] high accepted before low
      if (hi_req)
      begin
        // [R1] [R7] high or compatibility vector
        next_st.vector  = `IC_VEC_HIGH;
        // [R11] clear high level enable
        next_st.ctrl.gh = 1'b0;
        // [R2] high nests over low service
        next_st.svc = (next_st.svc == SVC_LOW) ? SVC_NEST
                                               : SVC_HIGH;
      end
      else
      begin
        // [R1] low vector
        next_st.vector  = `IC_VEC_LOW;
        // [R11] clear low level enable
        next_st.ctrl.pl = 1'b0;
        next_st.svc     = SVC_LOW;
      end
    end
  end

  // Whole controller frozen while clock enable is low, except that reset still loads
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      st <= reset_state();
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  assign axi_rsp_o    = st.rsp;
  assign pc_load_o    = st.pc_load;
  assign push_stack_o = st.push;
  assign vector_o     = st.vector;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_high_vector: assert property ( // [R1]
    $past(ce_i) && pc_load_o && in_high |-> vector_o == 21'h000008)
    else $error("high service without high vector");

  a_push_load: assert property ( // [R13]
    pc_load_o |-> push_stack_o && (vector_o == 21'h000008 ||
                                   vector_o == 21'h000018))
    else $error("vector load without stack push");

  a_compat_vector: assert property ( // [R7]
    $past(ce_i) && pc_load_o && !$past(st.ctrl.pm)
    |-> vector_o == 21'h000008)
    else $error("compatibility mode used low vector");

  a_gate_needed: assert property ( // [R9]
    $past(ce_i) && $rose(pc_load_o) |-> $past(st.ctrl.gh))
    else $error("interrupt taken with global enable clear");

  a_high_clears: assert property ( // [R11]
    $past(ce_i) && pc_load_o && vector_o == 21'h000008
    |-> !st.ctrl.gh && in_high)
    else $error("high entry left global enable set");

  a_low_clears: assert property ( // [R11]
    $past(ce_i) && pc_load_o && vector_o == 21'h000018
    |-> !st.ctrl.pl && st.svc == SVC_LOW)
    else $error("low entry left low enable set");

  a_low_held: assert property ( // [R12]
    in_high && ce_i |=> !(pc_load_o && vector_o == 21'h000018))
    else $error("low taken during high service");

  a_flag_sets: assert property ( // [R17]
    ce_i |=> (st.flags & $past(event_i)) == $past(event_i))
    else $error("event did not set its flag");

  a_return_high: assert property ( // [R15]
    ce_i && ret_instr_i && st.svc == SVC_HIGH && !fire
    |=> st.ctrl.gh && st.svc == SVC_NONE)
    else $error("return did not restore high enable");

  a_pin_latency: assert property ( // [R16]
    ce_i && !instr_strobe_i && st.lat == 2'h2 |=> !pc_load_o)
    else $error("dispatch without instruction strobe");
endmodule : irq_ctrl
`default_nettype wire

// file: verification/core_model.sv
// Processor core stand-in facing the interrupt controller.
// Assumes one-cycle entry pulses and a bench-driven return request.
`timescale 1ns/1ns
`default_nettype none
module core_model #(
  parameter int STRIDE = 2
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Controller side
  input  wire logic pc_load_i,
  input  wire logic push_i,
  input  wire logic ret_req_i,
  output logic      strobe_o,
  output logic      ret_instr_o,
  output var int    entries_o,
  output var int    bad_push_o
);
  int cnt;

  // Fixed pace, as if every instruction took STRIDE clocks
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      cnt      <= 0;
      strobe_o    <= 1'b0;
      ret_instr_o <= 1'b0;
    end
    else
    begin
      cnt      <= (cnt + 1) % STRIDE;
      strobe_o    <= (cnt == 0);
      ret_instr_o <= ret_req_i;
    end
  end

  // Stack push must travel with every vector load
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      entries_o  <= 0;
      bad_push_o <= 0;
    end
    else
    begin
      entries_o  <= entries_o + int'(pc_load_i);
      bad_push_o <= bad_push_o + int'(pc_load_i != push_i);
    end
  end
endmodule : core_model
`default_nettype wire

// file: verification/irq_ctrl_test.sv
// Self-checking bench for the two level interrupt controller.
// Assumes the core model paces instructions every second clock.
`include "irq_ctrl_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl_test;
  import irq_ctrl_pkg::*;
  logic        clock;
  logic        rst_n;
  logic        ce;
  axi_req_t    req;
  axi_rsp_t    rsp;
  logic [2:0]  pins;
  logic [63:0] evt;
  logic        strobe;
  logic        ret_instr;
  logic        ret_req;
  logic        pc_load;
  logic        push;
  logic [20:0] vec;
  int          entries;
  int          bad_push;
  int          num_errors;
  int          tests_run;

  irq_ctrl dut (.clock_i(clock), .rst_n_i(rst_n), .ce_i(ce),
    .axi_req_i(req), .axi_rsp_o(rsp), .ext_pin_i(pins),
    .event_i(evt), .instr_strobe_i(strobe), .ret_instr_i(ret_instr),
    .pc_load_o(pc_load), .push_stack_o(push), .vector_o(vec));

  core_model core (.clock_i(clock), .rst_n_i(rst_n),
    .pc_load_i(pc_load), .push_i(push), .ret_req_i(ret_req),
    .strobe_o(strobe), .ret_instr_o(ret_instr), .entries_o(entries),
    .bad_push_o(bad_push));

  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic chk(input string s, input logic [31:0] x,
                     input logic [31:0] g);
    tests_run++;
    if (g !== x)
    begin
      $display("CHECK FAILED %s exp %h got %h", s, x, g);
      num_errors++;
    end
  endtask : chk

  task automatic wr(input logic [13:0] i, input logic [7:0] d,
                    output logic [1:0] r);
    logic a;
    logic w;
    logic b;
    req.awaddr  <= {i, 2'b00};
    req.wdata   <= {24'h000000, d};
    req.wstrb   <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    b = 1'b0;
    // Ends on bvalid; only the watchdog bounds this wait
    while (!b)
    begin
      @(negedge clock);
      a = rsp.awready;
      w = rsp.wready;
      b = rsp.bvalid;
      r = rsp.bresp;
      @(posedge clock);
      if (a)
        req.awvalid <= 1'b0;
      if (w)
        req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
    // Idle edge so a following call never re-drives in this step
    @(posedge clock);
    chk("bvalid", 32'h1, {31'h0, b});
  endtask : wr

  task automatic rd(input logic [13:0] i, output logic [7:0] d,
                    output logic [1:0] r);
    logic a;
    logic v;
    req.araddr  <= {i, 2'b00};
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    v = 1'b0;
    while (!v)
    begin
      @(negedge clock);
      a = rsp.arready;
      v = rsp.rvalid;
      d = rsp.rdata[7:0];
      r = rsp.rresp;
      @(posedge clock);
      if (a)
        req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
    @(posedge clock);
    chk("rvalid", 32'h1, {31'h0, v});
  endtask : rd

  task automatic wc(input logic [13:0] i, input logic [7:0] d);
    logic [1:0] r;
    // register write that must get an OKAY response
    wr(i, d, r);
    chk("wresp", `IC_RESP_OKAY, r);
  endtask : wc

  task automatic rc(input string s, input logic [13:0] i,
                    input logic [7:0] x);
    logic [7:0] d;
    logic [1:0] r;
    rd(i, d, r);
    chk("rresp", `IC_RESP_OKAY, r);
    chk(s, x, d);
  endtask : rc

  task automatic clr();
    wc(`IC_FLAG_IDX, 8'h00);
    wc(`IC_FLAG_IDX + 14'h0001, 8'h00);
  endtask : clr

  // One event burst, then entry count, vector and enables
  task automatic step(input logic [63:0] m, input logic f,
                      input logic [20:0] v, input logic [7:0] c);
    int e0;
    e0 = entries;
    evt <= m;
    @(posedge clock);
    evt <= 64'h0;
    repeat (16) @(posedge clock);
    chk("entries", e0 + f, entries);
    if (f)
      chk("vector", v, vec);
    rc("control", `IC_CTRL_IDX, c);
  endtask : step

  task automatic ret(input logic [7:0] c);
    ret_req <= 1'b1;
    @(posedge clock);
    ret_req <= 1'b0;
    repeat (3) @(posedge clock);
    rc("ret control", `IC_CTRL_IDX, c);
  endtask : ret

  task automatic pin(input logic l, input logic f);
    int e0;
    e0 = entries;
    pins[0] <= l;
    repeat (3) @(posedge clock);
    chk("early", e0, entries);
    repeat (13) @(posedge clock);
    chk("pin entry", e0 + f, entries);
  endtask : pin

  task automatic t_regs();
    logic [7:0] d;
    logic [1:0] r;
    rc("ctrl reset", `IC_CTRL_IDX, 8'h07);
    for (int k = 0; k < 8; k++)
      wc(`IC_ENAB_IDX + 14'(k), 8'hA0 | 8'(k));
    for (int k = 0; k < 8; k++)
      rc("enable", `IC_ENAB_IDX + 14'(k), 8'hA0 | 8'(k));
    wc(`IC_FLAG_IDX + 14'h0007, 8'h81);
    rc("flag7", `IC_FLAG_IDX + 14'h0007, 8'h81);
    wc(`IC_FLAG_IDX + 14'h0007, 8'h00);
    wc(`IC_CTRL_IDX, 8'hFF);
    rc("ctrl mask", `IC_CTRL_IDX, 8'hE7);
    wr(14'h0000, 8'hFF, r);
    chk("unmapped wr", `IC_RESP_SLVERR, r);
    rd(14'h0000, d, r);
    chk("unmapped rd", `IC_RESP_SLVERR, r);
    chk("unmapped data", 32'h0, d);
    wc(`IC_CTRL_IDX, 8'h07);
  endtask : t_regs

  task automatic t_compat();
    wc(`IC_ENAB_IDX, 8'h01);
    wc(`IC_ENAB_IDX + 14'h0001, 8'h01);
    step(64'h200, 0, 0, 8'h07);
    rc("flag1", `IC_FLAG_IDX + 14'h0001, 8'h02);
    clr();
    wc(`IC_CTRL_IDX, 8'h87);
    step(64'h100, 0, 0, 8'h87);
    clr();
    step(64'h1, 1, `IC_VEC_HIGH, 8'h07);
    clr();
    ret(8'h87);
    wc(`IC_CTRL_IDX, 8'hC7);
    step(64'h100, 1, `IC_VEC_HIGH, 8'h47);
    clr();
    ret(8'hC7);
    wc(`IC_CTRL_IDX, 8'h47);
    step(64'h1, 0, 0, 8'h47);
    clr();
  endtask : t_compat

  task automatic t_prio();
    wc(`IC_PRIO_IDX, 8'h01);
    wc(`IC_CTRL_IDX, 8'hA7);
    step(64'h100, 0, 0, 8'hA7);
    clr();
    wc(`IC_CTRL_IDX, 8'h27);
    step(64'h1, 0, 0, 8'h27);
    clr();
    wc(`IC_CTRL_IDX, 8'hE7);
    step(64'h100, 1, `IC_VEC_LOW, 8'hA7);
    step(64'h1, 1, `IC_VEC_HIGH, 8'h27);
    clr();
    ret(8'hA7);
    ret(8'hE7);
    step(64'h1, 1, `IC_VEC_HIGH, 8'h67);
    clr();
    wc(`IC_CTRL_IDX, 8'hE7);
    step(64'h100, 0, 0, 8'hE7);
    clr();
    ret(8'hE7);
    step(64'h101, 1, `IC_VEC_HIGH, 8'h67);
    clr();
    ret(8'hE7);
  endtask : t_prio

  task automatic t_pins();
    wc(`IC_PRIO_IDX, 8'h00);
    wc(`IC_CTRL_IDX, 8'h87);
    pin(1'b1, 1'b1);
    clr();
    ret(8'h87);
    wc(`IC_CTRL_IDX, 8'h86);
    pin(1'b0, 1'b1);
    clr();
    ret(8'h86);
    pin(1'b1, 1'b0);
    chk("push pairing", 32'h0, bad_push);
  endtask : t_pins

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    complete_run();
  end

  initial
  begin
    num_errors = 0;
    tests_run  = 0;
    rst_n      = 1'b0;
    ce         = 1'b1;
    req        = '0;
    pins       = 3'h0;
    evt        = 64'h0;
    ret_req    = 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_compat();
    t_prio();
    t_pins();
    complete_run();
  end
endmodule : irq_ctrl_test
`default_nettype wire
